// File: rtl/pri_pulse_ref.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1 - repetition frequency evaluation only with mode code 20 or 21
// RULE2 - mode 20 counts one edge per input period
// RULE3 - mode 21 counts both rising and falling edges
// RULE4 - mode 0, the reset default, makes the measured frequency zero
// RULE5 - any pulse mode takes the pin away from other input functions
// RULE6 - a source selector holding 10 contributes the pulse derived frequency
// RULE7 - divider setting spans 1 to 8192, default 1024
// RULE8 - rotational frequency is pulse rate divided by the divider
// RULE9 - evaluated repetition or pulse train value is readable
// RULE10 - percentage output is evaluated frequency over maximum frequency times 100
// RULE11 - pulse train evaluation only with mode code 30
// RULE12 - scaling frequency spans 0 to 32000 Hz, default 25000
// RULE13 - pulse train reference is input times maximum over scaling frequency
// RULE14 - scaling frequency 0 passes the input frequency through unscaled
// RULE15 - pulse derived reference never exceeds maximum frequency
// RULE16 - fixed frequency on a source, code 3, is summed as offset
// RULE17 - pin is passed through two flip-flops before edge detection
// RULE18 - edges are counted over a fixed gate, result updates per gate
module pri_pulse_ref
	import pri_pkg::*;
#(
	parameter int unsigned GATE_CYC = pri_pkg::GATE_CYCLES,
	parameter int unsigned MEAS_W   = 24
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire pri_pkg::pri_axil_req_t axi_req,
	output pri_pkg::pri_axil_rsp_t      axi_rsp_q,
	input  wire logic                   pulse_input_terminal,
	output logic                        pin_owned_q,
	output logic                        other_func_in_q,
	output logic [16:0]                 ref_freq_q,
	output logic [15:0]                 ref_pct_q
);
	import pri_pkg::*;

	localparam int unsigned NUM_W = 40;

	// settings
	logic [7:0]  mode_q, mode_d;
	logic [13:0] div_q, div_d;
	logic [15:0] scale_q, scale_d;
	logic [15:0] fmax_q, fmax_d;
	logic [7:0]  src1_q, src1_d;
	logic [7:0]  src2_q, src2_d;
	logic [15:0] fixed_q, fixed_d;

	// bus slave state
	logic                  aw_got_q, aw_got_d;
	logic                  w_got_q, w_got_d;
	logic [AXI_AW-1:0]     aw_addr_q, aw_addr_d;
	logic [AXI_DW-1:0]     w_data_q, w_data_d;
	logic [3:0]            w_strb_q, w_strb_d;
	pri_pkg::pri_axil_rsp_t rsp_d;
	logic [AXI_DW-1:0]     wmask;
	logic [AXI_DW-1:0]     wval;

	// measurement state
	logic              sync1_q, sync2_q, prev_q;
	logic [31:0]       gate_q, gate_d;
	logic [MEAS_W-1:0] edges_q, edges_d;
	logic [MEAS_W-1:0] meas_q, meas_d;
	logic              tick_q, tick_d;
	logic              rf_mode, pt_mode, pin_owned_d;
	logic              qual_edge;
	logic [31:0]       gate_len;

	// computation state
	pri_calc_t         calc_q, calc_d;
	logic              dstart_q, dstart_d;
	logic [NUM_W-1:0]  dnum_q, dnum_d;
	logic [15:0]       dden_q, dden_d;
	logic              ddone;
	logic [NUM_W-1:0]  dquot;
	logic [15:0]       actual_q, actual_d;
	logic [15:0]       pref_q, pref_d;
	logic [15:0]       pct_q, pct_d;
	logic [16:0]       ref_freq_d;

	// byte lane mask from write strobes
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{w_strb_q[gi]}};
		end
	endgenerate
	assign wval = w_data_q & wmask;

	assign rf_mode = (mode_q == MODE_RF_SINGLE) || (mode_q == MODE_RF_DOUBLE); // see RULE1
	assign pt_mode = (mode_q == MODE_PULSE_TRAIN);                            // see RULE11
	assign pin_owned_d = rf_mode || pt_mode || (mode_q == MODE_PWM_UNI)
		|| (mode_q == MODE_PWM_BI);                                           // see RULE5

	// qualified edges per mode
	always_comb begin
		qual_edge = 1'b0;
		if (mode_q == MODE_RF_DOUBLE) begin
			qual_edge = sync2_q ^ prev_q;                                     // see RULE3
		end else if ((mode_q == MODE_RF_SINGLE) || pt_mode) begin
			qual_edge = sync2_q & ~prev_q;                                    // see RULE2
		end
	end

	// double edge mode halves the gate so the result stays in hertz
	assign gate_len = (mode_q == MODE_RF_DOUBLE) ? (GATE_CYC / 2) : GATE_CYC;

	// gate timer and edge counter
	always_comb begin
		gate_d  = gate_q + 32'd1;
		edges_d = edges_q;
		meas_d  = meas_q;
		tick_d  = 1'b0;
		if (qual_edge && (edges_q != '1)) begin
			edges_d = edges_q + MEAS_W'(1);
		end
		if (gate_q >= gate_len - 32'd1) begin                                   // see RULE18
			gate_d  = '0;
			// an edge in the closing cycle opens the next gate, so none is lost
			edges_d = MEAS_W'(qual_edge);
			tick_d  = 1'b1;
			meas_d  = (rf_mode || pt_mode) ? edges_q : '0;                   // see RULE4
		end
	end

	// synchroniser, edge history and measurement registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			gate_q  <= '0;
			edges_q <= '0;
			meas_q  <= '0;
			tick_q  <= 1'b0;
		end else begin
			sync1_q <= pulse_input_terminal;                                 // see RULE17
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			gate_q  <= gate_d;
			edges_q <= edges_d;
			meas_q  <= meas_d;
			tick_q  <= tick_d;
		end
	end

	pri_divider #(
		.NUM_W (NUM_W),
		.DEN_W (16)
	) u_div (
		.clk    (clk),
		.rstn   (rstn),
		.start  (dstart_q),
		.num    (dnum_q),
		.den    (dden_q),
		.done_q (ddone),
		.quot_q (dquot)
	);

	// scaling, clamping and percentage sequence, run once per gate
	always_comb begin
		calc_d   = calc_q;
		dstart_d = 1'b0;
		dnum_d   = dnum_q;
		dden_d   = dden_q;
		actual_d = actual_q;
		pref_d   = pref_q;
		pct_d    = pct_q;
		unique case (calc_q)
			CALC_IDLE: begin
				if (tick_q) begin
					if (rf_mode) begin
						dnum_d   = NUM_W'(meas_q) * NUM_W'(CHZ_PER_HZ);    // see RULE8
						dden_d   = 16'(div_q);                             // see RULE7
						dstart_d = 1'b1;
						calc_d   = CALC_REF;
					end else if (pt_mode && (scale_q != '0)) begin
						dnum_d   = NUM_W'(meas_q) * NUM_W'(fmax_q);        // see RULE13
						dden_d   = scale_q;
						dstart_d = 1'b1;
						calc_d   = CALC_REF;
					end else if (pt_mode) begin
						dnum_d   = NUM_W'(meas_q) * NUM_W'(CHZ_PER_HZ);    // see RULE14
						dden_d   = 16'h0001;
						dstart_d = 1'b1;
						calc_d   = CALC_REF;
					end else begin
						actual_d = '0;
						pref_d   = '0;
						pct_d    = '0;
					end
				end
			end
			CALC_REF: begin
				if (ddone) begin
					actual_d = (dquot > NUM_W'(16'hFFFF)) ? 16'hFFFF : dquot[15:0]; // see RULE9
					pref_d   = (dquot > NUM_W'(fmax_q)) ? fmax_q : dquot[15:0]; // see RULE15
					if (fmax_q == '0) begin
						pct_d  = '0;
						calc_d = CALC_IDLE;
					end else begin
						dnum_d   = NUM_W'(pref_d) * NUM_W'(PCT_FULL);      // see RULE10
						dden_d   = fmax_q;
						dstart_d = 1'b1;
						calc_d   = CALC_PCT;
					end
				end
			end
			CALC_PCT: begin
				if (ddone) begin
					pct_d  = dquot[15:0];
					calc_d = CALC_IDLE;
				end
			end
			default: calc_d = CALC_IDLE;
		endcase
	end

	// reference channel: a source holding code 10 or 3 adds pulse or fixed frequency
	always_comb begin
		ref_freq_d = '0;
		if (src1_q == SRC_PULSE) ref_freq_d = ref_freq_d + 17'(pref_q);      // see RULE6
		if (src2_q == SRC_PULSE) ref_freq_d = ref_freq_d + 17'(pref_q);      // see RULE6
		if (src1_q == SRC_FIXED) ref_freq_d = ref_freq_d + 17'(fixed_q);     // see RULE16
		if (src2_q == SRC_FIXED) ref_freq_d = ref_freq_d + 17'(fixed_q);     // see RULE16
	end

	// computation and output registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			calc_q          <= CALC_IDLE;
			dstart_q        <= 1'b0;
			dnum_q          <= '0;
			dden_q          <= '0;
			actual_q        <= '0;
			pref_q          <= '0;
			pct_q           <= '0;
			ref_freq_q      <= '0;
			ref_pct_q       <= '0;
			pin_owned_q     <= 1'b0;
			other_func_in_q <= 1'b0;
		end else begin
			calc_q          <= calc_d;
			dstart_q        <= dstart_d;
			dnum_q          <= dnum_d;
			dden_q          <= dden_d;
			actual_q        <= actual_d;
			pref_q          <= pref_d;
			pct_q           <= pct_d;
			ref_freq_q      <= ref_freq_d;
			ref_pct_q       <= pct_q;
			pin_owned_q     <= pin_owned_d;
			other_func_in_q <= sync2_q & ~pin_owned_d;                       // see RULE5
		end
	end

	// axi4-lite slave: address and data taken in either order
	always_comb begin
		aw_got_d  = aw_got_q;
		w_got_d   = w_got_q;
		aw_addr_d = aw_addr_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		rsp_d     = axi_rsp_q;
		mode_d    = mode_q;
		div_d     = div_q;
		scale_d   = scale_q;
		fmax_d    = fmax_q;
		src1_d    = src1_q;
		src2_d    = src2_q;
		fixed_d   = fixed_q;
		if (axi_req.awvalid && axi_rsp_q.awready) begin
			aw_got_d  = 1'b1;
			aw_addr_d = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp_q.wready) begin
			w_got_d  = 1'b1;
			w_data_d = axi_req.wdata;
			w_strb_d = axi_req.wstrb;
		end
		if (axi_rsp_q.bvalid && axi_req.bready) rsp_d.bvalid = 1'b0;
		if (aw_got_q && w_got_q && !axi_rsp_q.bvalid) begin
			aw_got_d    = 1'b0;
			w_got_d     = 1'b0;
			rsp_d.bvalid = 1'b1;
			rsp_d.bresp  = RESP_OKAY;
			unique case ({aw_addr_q[AXI_AW-1:2], 2'b00})
				OFS_MODE:  mode_d  = (mode_q & ~wmask[7:0]) | wval[7:0];
				OFS_DIV: begin
					div_d = (div_q & ~wmask[13:0]) | wval[13:0];
					if (div_d < DIV_MIN) div_d = DIV_MIN;                  // see RULE7
					if (div_d > DIV_MAX) div_d = DIV_MAX;
				end
				OFS_SCALE: begin
					scale_d = (scale_q & ~wmask[15:0]) | wval[15:0];
					if (scale_d > SCALE_MAX) scale_d = SCALE_MAX;          // see RULE12
				end
				OFS_FMAX:  fmax_d  = (fmax_q & ~wmask[15:0]) | wval[15:0];
				OFS_SRC1:  src1_d  = (src1_q & ~wmask[7:0]) | wval[7:0];
				OFS_SRC2:  src2_d  = (src2_q & ~wmask[7:0]) | wval[7:0];
				OFS_FIXED: fixed_d = (fixed_q & ~wmask[15:0]) | wval[15:0];
				OFS_MEAS, OFS_ACTUAL, OFS_REF, OFS_PCT: ;
				default:   rsp_d.bresp = RESP_DECERR;
			endcase
		end
		rsp_d.awready = !aw_got_d && !rsp_d.bvalid;
		rsp_d.wready  = !w_got_d && !rsp_d.bvalid;
		// read channel
		if (axi_rsp_q.rvalid && axi_req.rready) rsp_d.rvalid = 1'b0;
		if (axi_req.arvalid && axi_rsp_q.arready) begin
			rsp_d.rvalid = 1'b1;
			rsp_d.rresp  = RESP_OKAY;
			unique case ({axi_req.araddr[AXI_AW-1:2], 2'b00})
				OFS_MODE:   rsp_d.rdata = 32'(mode_q);
				OFS_DIV:    rsp_d.rdata = 32'(div_q);
				OFS_SCALE:  rsp_d.rdata = 32'(scale_q);
				OFS_FMAX:   rsp_d.rdata = 32'(fmax_q);
				OFS_SRC1:   rsp_d.rdata = 32'(src1_q);
				OFS_SRC2:   rsp_d.rdata = 32'(src2_q);
				OFS_FIXED:  rsp_d.rdata = 32'(fixed_q);
				OFS_MEAS:   rsp_d.rdata = 32'(meas_q);
				OFS_ACTUAL: rsp_d.rdata = 32'(actual_q);                      // see RULE9
				OFS_REF:    rsp_d.rdata = 32'(ref_freq_q);
				OFS_PCT:    rsp_d.rdata = 32'(pct_q);
				default: begin
					rsp_d.rdata = '0;
					rsp_d.rresp = RESP_DECERR;
				end
			endcase
		end
		rsp_d.arready = !rsp_d.rvalid;
	end

	// bus and settings registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			axi_rsp_q <= '0;
			mode_q    <= MODE_OFF;                                           // see RULE4
			div_q     <= DIV_RST;
			scale_q   <= SCALE_RST;
			fmax_q    <= FMAX_RST;
			src1_q    <= SRC_RST;
			src2_q    <= SRC_RST;
			fixed_q   <= FIXED_RST;
		end else begin
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			aw_addr_q <= aw_addr_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			axi_rsp_q <= rsp_d;
			mode_q    <= mode_d;
			div_q     <= div_d;
			scale_q   <= scale_d;
			fmax_q    <= fmax_d;
			src1_q    <= src1_d;
			src2_q    <= src2_d;
			fixed_q   <= fixed_d;
		end
	end

endmodule : pri_pulse_ref

`default_nettype wire

// File: common/pri_pkg.sv
package pri_pkg;

	// clock and gate timing
	localparam int unsigned CLK_FREQ_HZ  = 125_000_000;
	localparam int unsigned GATE_TIME_MS = 1000;
	localparam int unsigned GATE_CYCLES  = CLK_FREQ_HZ / 1000 * GATE_TIME_MS;

	// bus geometry
	localparam int unsigned AXI_AW = 8;
	localparam int unsigned AXI_DW = 32;

	// register byte offsets
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_DIV    = 8'h04;
	localparam logic [7:0] OFS_SCALE  = 8'h08;
	localparam logic [7:0] OFS_FMAX   = 8'h0C;
	localparam logic [7:0] OFS_SRC1   = 8'h10;
	localparam logic [7:0] OFS_SRC2   = 8'h14;
	localparam logic [7:0] OFS_FIXED  = 8'h18;
	localparam logic [7:0] OFS_MEAS   = 8'h20;
	localparam logic [7:0] OFS_ACTUAL = 8'h24;
	localparam logic [7:0] OFS_REF    = 8'h28;
	localparam logic [7:0] OFS_PCT    = 8'h2C;

	// pulse_input_mode_setting codes
	localparam logic [7:0] MODE_OFF         = 8'h00;
	localparam logic [7:0] MODE_PWM_UNI     = 8'h0A;
	localparam logic [7:0] MODE_PWM_BI      = 8'h0B;
	localparam logic [7:0] MODE_RF_SINGLE   = 8'h14;
	localparam logic [7:0] MODE_RF_DOUBLE   = 8'h15;
	localparam logic [7:0] MODE_PULSE_TRAIN = 8'h1E;

	// reference source selector codes
	localparam logic [7:0] SRC_FIXED = 8'h03;
	localparam logic [7:0] SRC_PULSE = 8'h0A;

	// setting limits and reset values
	localparam logic [13:0] DIV_MIN   = 14'h0001;
	localparam logic [13:0] DIV_MAX   = 14'h2000;
	localparam logic [13:0] DIV_RST   = 14'h0400;
	localparam logic [15:0] SCALE_MAX = 16'h7D00;
	localparam logic [15:0] SCALE_RST = 16'h61A8;
	localparam logic [15:0] FMAX_RST  = 16'h1388;
	localparam logic [15:0] FIXED_RST = 16'h0000;
	localparam logic [7:0]  SRC_RST   = 8'h00;

	// unit scaling: frequencies in 0.01 Hz, percentage in 0.01 %
	localparam logic [15:0] CHZ_PER_HZ = 16'h0064;
	localparam logic [15:0] PCT_FULL   = 16'h2710;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// master to slave
	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} pri_axil_req_t;

	// slave to master
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0]        rresp;
	} pri_axil_rsp_t;

	// computation sequencer, gray coded
	typedef enum logic [1:0] {
		CALC_IDLE = 2'b00,
		CALC_REF  = 2'b01,
		CALC_PCT  = 2'b11
	} pri_calc_t;

endpackage : pri_pkg

// File: rtl/pri_divider.sv
`timescale 1ns/1ps
`default_nettype none

// serial restoring divider, one quotient bit per clock
module pri_divider #(
	parameter int unsigned NUM_W = 40,
	parameter int unsigned DEN_W = 16
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             start,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	output logic                  done_q,
	output logic [NUM_W-1:0]      quot_q
);
	localparam int unsigned CW = $clog2(NUM_W + 1);

	logic             busy_q, busy_d;
	logic             done_d;
	logic [DEN_W-1:0] rem_q, rem_d;
	logic [DEN_W-1:0] den_q, den_d;
	logic [NUM_W-1:0] quo_q, quo_d;
	logic [NUM_W-1:0] quot_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic [DEN_W:0]   trial;

	// next state of the shift and subtract loop
	always_comb begin
		busy_d = busy_q;
		done_d = 1'b0;
		rem_d  = rem_q;
		den_d  = den_q;
		quo_d  = quo_q;
		quot_d = quot_q;
		cnt_d  = cnt_q;
		trial  = {rem_q, quo_q[NUM_W-1]};
		if (start) begin
			busy_d = 1'b1;
			rem_d  = '0;
			den_d  = den;
			quo_d  = num;
			cnt_d  = CW'(NUM_W);
		end else if (busy_q) begin
			if (trial >= {1'b0, den_q}) begin
				rem_d = DEN_W'(trial - {1'b0, den_q});
				quo_d = {quo_q[NUM_W-2:0], 1'b1};
			end else begin
				rem_d = trial[DEN_W-1:0];
				quo_d = {quo_q[NUM_W-2:0], 1'b0};
			end
			cnt_d = cnt_q - CW'(1);
			if (cnt_q == CW'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				quot_d = quo_d;
			end
		end
	end

	// state registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rem_q  <= '0;
			den_q  <= '0;
			quo_q  <= '0;
			quot_q <= '0;
			cnt_q  <= '0;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			rem_q  <= rem_d;
			den_q  <= den_d;
			quo_q  <= quo_d;
			quot_q <= quot_d;
			cnt_q  <= cnt_d;
		end
	end

endmodule : pri_divider

`default_nettype wire

// File: dv/pri_pulse_ref_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// port level checks of the pulse reference block
module pri_pulse_ref_monitor
	import pri_pkg::*;
#(
	parameter int unsigned GATE_CYC = 1000
) (
	input wire logic                   clk,
	input wire logic                   rstn,
	input wire pri_pkg::pri_axil_req_t axi_req,
	input wire pri_pkg::pri_axil_rsp_t axi_rsp_q,
	input wire logic                   pulse_input_terminal,
	input wire logic                   pin_owned_q,
	input wire logic                   other_func_in_q,
	input wire logic [16:0]            ref_freq_q,
	input wire logic [15:0]            ref_pct_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	logic [31:0] gap_q, gap_d;
	logic        seen_q, seen_d;
	logic [15:0] last_q;

	// cycles since the percentage output last moved
	always_comb begin
		gap_d = (ref_pct_q != last_q) ? 32'h0 : gap_q + 32'h1;
		seen_d = seen_q | (ref_pct_q != last_q);
	end

	// registers of the spacing counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gap_q <= 32'h0;
			seen_q <= 1'b0;
			last_q <= 16'h0;
		end else begin
			gap_q <= gap_d;
			seen_q <= seen_d;
			last_q <= ref_pct_q;
		end
	end

	a_pin_exclusive: assert property (pin_owned_q |-> !other_func_in_q)
		else $error("pin copy active while pin owned");
	a_sync_stages: assert property ($rose(other_func_in_q) |-> $past(pulse_input_terminal, 3))
		else $error("pin copy rose too early");
	a_pct_ceiling: assert property (ref_pct_q <= PCT_FULL)
		else $error("percentage above full scale");
	a_gate_spacing: assert property ((ref_pct_q != last_q) && seen_q |-> gap_q >= GATE_CYC / 4)
		else $error("result updated faster than the gate");
	a_wr_answer: assert property (axi_req.awvalid && axi_rsp_q.awready && axi_req.wvalid
		&& axi_rsp_q.wready |-> ##2 axi_rsp_q.bvalid) else $error("write response late");
	a_rd_answer: assert property (axi_req.arvalid && axi_rsp_q.arready |=> axi_rsp_q.rvalid)
		else $error("read response late");
	a_ar_blocked: assert property (axi_rsp_q.rvalid |-> !axi_rsp_q.arready)
		else $error("read address accepted during answer");
	a_b_holds: assert property (axi_rsp_q.bvalid && !axi_req.bready
		|=> axi_rsp_q.bvalid && $stable(axi_rsp_q.bresp)) else $error("write response dropped");
	a_r_holds: assert property (axi_rsp_q.rvalid && !axi_req.rready
		|=> axi_rsp_q.rvalid && $stable(axi_rsp_q.rdata)) else $error("read data dropped");

	c_write: cover property (axi_req.awvalid && axi_rsp_q.awready);
	c_read: cover property (axi_rsp_q.rvalid && axi_req.rready);
	c_owned: cover property ($rose(pin_owned_q));
endmodule : pri_pulse_ref_monitor

bind pri_pulse_ref pri_pulse_ref_monitor #(.GATE_CYC(GATE_CYC)) u_mon (.clk(clk), .rstn(rstn),
	.axi_req(axi_req), .axi_rsp_q(axi_rsp_q), .pulse_input_terminal(pulse_input_terminal),
	.pin_owned_q(pin_owned_q), .other_func_in_q(other_func_in_q), .ref_freq_q(ref_freq_q),
	.ref_pct_q(ref_pct_q));
`default_nettype wire

// File: dv/pri_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

// square wave source, low and still while disabled
module pri_pulse_src #(
	parameter int unsigned HALF_NS = 40
) (
	input wire logic en,
	output logic     pin
);
	// phase kept off the clock edges
	initial begin
		pin = 1'b0;
		#3;
		forever begin
			#(HALF_NS);
			pin = en ? ~pin : 1'b0;
		end
	end
endmodule : pri_pulse_src
`default_nettype wire

// File: dv/pri_pulse_ref_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %0h seen %0h", n, e, g); end end

module pri_pulse_ref_bench;
	import pri_pkg::*;
	localparam int unsigned GATE = 1000;
	logic          clk, rstn, src_en, pin, owned, other;
	logic [16:0]   ref_freq;
	logic [15:0]   ref_pct, fixed_v;
	logic [33:0]   note;
	logic [31:0]   ms, act, pref;
	pri_axil_req_t req;
	pri_axil_rsp_t rsp;
	logic [33:0]   exp_q[$];
	int            n_mismatch = 0;
	int            total_checks = 0;
	logic [7:0]    cm[10] = '{8'h14, 8'h15, 8'h1E, 8'h1E, 8'h1E, 8'h00, 8'h0A, 8'h0B, 8'h14, 8'h14};
	logic [31:0]   cd[10] = '{4, 1, 1, 1, 1, 1, 1, 1, 32'h2000, 1};
	logic [31:0]   cs[10] = '{9, 9, 200, 0, 100, 9, 9, 9, 9, 9};
	logic          ce[10] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
	logic [31:0]   fm[2] = '{32'h0BB8, 32'h0};

	pri_pulse_ref #(.GATE_CYC(GATE)) dut (.clk(clk), .rstn(rstn), .axi_req(req),
		.axi_rsp_q(rsp), .pulse_input_terminal(pin), .pin_owned_q(owned),
		.other_func_in_q(other), .ref_freq_q(ref_freq), .ref_pct_q(ref_pct));
	pri_pulse_src #(.HALF_NS(40)) u_src (.en(src_en), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// one write, response noted for the watcher
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		exp_q.push_back({r, 32'h0});
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
	endtask : wr

	// one read, expected word noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		exp_q.push_back({r, d});
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
	endtask : rd

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// watcher: oldest note against each bus answer
	always @(posedge clk) begin
		if (rsp.bvalid && req.bready) begin
			note = exp_q.pop_front();
			`CHK("write response", note, {rsp.bresp, 32'h0})
		end
		if (rsp.rvalid && req.rready) begin
			note = exp_q.pop_front();
			`CHK("read word", note, {rsp.rresp, rsp.rdata})
		end
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		rstn = 1'b0;
		src_en = 1'b0;
		req = '0;
		void'($urandom(66011));
		fixed_v = 16'($urandom_range(1023));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		src_en <= 1'b1;
		rd(OFS_MODE, 32'(MODE_OFF));
		rd(OFS_DIV, 32'(DIV_RST));
		rd(OFS_SCALE, 32'(SCALE_RST));
		rd(8'h1C, 32'h0, RESP_DECERR);
		wr(8'h1C, 32'h5, RESP_DECERR);
		wr(OFS_MEAS, 32'h1234);
		rd(OFS_MEAS, 32'h0);
		wr(OFS_DIV, 32'h0);
		rd(OFS_DIV, 32'(DIV_MIN));
		wr(OFS_DIV, 32'h2328);
		rd(OFS_DIV, 32'(DIV_MAX));
		wr(OFS_SCALE, 32'h9C40);
		rd(OFS_SCALE, 32'(SCALE_MAX));
		wr(OFS_SRC1, 32'(SRC_PULSE));
		wr(OFS_SRC2, 32'(SRC_FIXED));
		wr(OFS_FIXED, 32'(fixed_v));
		for (int i = 0; i < 10; i++) begin
			wr(OFS_MODE, 32'(cm[i]));
			wr(OFS_DIV, cd[i]);
			wr(OFS_SCALE, cs[i]);
			src_en <= ce[i];
			repeat (2 * GATE + 200) @(posedge clk);
			ms = (ce[i] && cm[i] inside {MODE_RF_SINGLE, MODE_RF_DOUBLE, MODE_PULSE_TRAIN}) ? 100 : 0;
			if (cm[i] != MODE_PULSE_TRAIN) act = ms * 32'(CHZ_PER_HZ) / cd[i];
			else if (cs[i] == 0) act = ms * 32'(CHZ_PER_HZ);
			else act = ms * 32'(FMAX_RST) / cs[i];
			pref = (act > 32'(FMAX_RST)) ? 32'(FMAX_RST) : act;
			rd(OFS_MEAS, ms);
			rd(OFS_ACTUAL, act);
			rd(OFS_REF, pref + 32'(fixed_v));
			rd(OFS_PCT, pref * 32'(PCT_FULL) / 32'(FMAX_RST));
			`CHK("ref_freq_q", pref + 32'(fixed_v), 32'(ref_freq))
			`CHK("pin_owned_q", cm[i] != MODE_OFF, owned)
			`CHK("ref_pct_q", 16'(pref * 32'(PCT_FULL) / 32'(FMAX_RST)), ref_pct)
		end
		// lower and zero maximum frequency with single edge mode, divider 1
		foreach (fm[j]) begin
			wr(OFS_FMAX, fm[j]);
			src_en <= 1'b1;
			repeat (2 * GATE + 200) @(posedge clk);
			act = 32'd100 * 32'(CHZ_PER_HZ);
			pref = (act > fm[j]) ? fm[j] : act;
			rd(OFS_FMAX, fm[j]);
			rd(OFS_ACTUAL, act);
			rd(OFS_REF, pref + 32'(fixed_v));
			rd(OFS_PCT, (fm[j] == 0) ? 32'h0 : pref * 32'(PCT_FULL) / fm[j]);
			`CHK("ref_freq_q", pref + 32'(fixed_v), 32'(ref_freq))
		end
		wrap_up();
	end
endmodule : pri_pulse_ref_bench
`default_nettype wire
